// [design/dds_ctrl_defs.vh]
// constants for the synthesizer phase, amplitude and ram mode control block
// assumes inclusion by the design file of this block and by its test bench
`ifndef DDS_CTRL_DEFS_VH
`define DDS_CTRL_DEFS_VH
// =====================================================================
// register byte offsets on apb
`define OFS_CTRL       12'h000
`define OFS_TUNING     12'h004
`define OFS_PHASE      12'h008
`define OFS_AMPL       12'h00C
`define OFS_RAMPRATE   12'h010
`define OFS_SEG0       12'h014
`define OFS_SEG1       12'h018
`define OFS_SEG2       12'h01C
`define OFS_SEG3       12'h020
`define OFS_STATUS     12'h024
// =====================================================================
// control_function_reg_one field positions
`define CF_RAM_EN      31
`define CF_RAM_DEST    30
`define CF_LOAD_RR     26
`define CF_OSK_EN      25
`define CF_OSK_AUTO    24
`define CF_ACLR_SWEEP  14
`define CF_ACLR_PHASE  13
`define CF_CCLR_SWEEP  11
`define CF_CCLR_PHASE  10
// reset: phase accumulator clear set in active copy, buffer cleared
`define CTRL_ACTIVE_RST 32'h0000_0400
`define CTRL_BUF_RST    32'h0000_0000
// =====================================================================
// amplitude_scale_field layout
`define AMP_STEP_HI    15
`define AMP_STEP_LO    14
`define AMP_VAL_HI     13
`define SCALE_FULL     14'h3FFF
`define SCALE_ZERO     14'h0000
// =====================================================================
// ram_segment_control_word layout
`define SEG_FINAL_HI   29
`define SEG_FINAL_LO   20
`define SEG_BEGIN_HI   19
`define SEG_BEGIN_LO   10
`define SEG_MODE_HI    7
`define SEG_MODE_LO    5
// segment mode codes
`define MODE_DIRECT    3'h0
`define MODE_RAMPUP    3'h1
`define MODE_BIDIR     3'h2
`define MODE_CBIDIR    3'h3
`define MODE_RECIRC    3'h4
// =====================================================================
// ram word bits used as phase offset in phase keying
`define RAM_PHASE_HI   31
`define RAM_PHASE_LO   18
`define RAMP_TIMER_ONE 8'h01
`endif

// [design/dds_phase_amp_ctrl.v]
// phase offset selection, accumulator clears, shaped keying and ram mode decode
// assumes: apb master on i_mclk, external ram answering o_ram_addr combinationally
// into i_ram_word, host pins asynchronous to i_mclk
//
// Functional notes
// - phase offset from register or ram word
// - 14-bit word is linear fraction of turn
// - phase path delayed to match tuning word
// - two auto-clear and two continuous-clear bits
// - auto-clear zeroes accumulator on each update event
// - keying enable bit and auto/manual select bit
// - auto counter steps up/down with keying pin
// - scale factor unsigned, zero to full value
// - step size 1,2,4,8 from top bits
// - auto counter limited by amplitude scale value
// - ramp timer down counter reloads at one
// - load bit adds reload on update events
// - early reload on keying toggle, update, profile
// - reload when auto keying becomes active
// - manual keying uses amplitude scale directly
// - single tone uses tuning register after update
// - profile change or update restarts ram sweep
// - destination bit routes ram to tuning/phase
// - segment mode decode, invalid codes direct switch
// - direct switch reads only begin address
// - profile pins select one of four ram segment words
// - update copies buffered values to active
//
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/100ps
`include "dds_ctrl_defs.vh"
module dds_phase_amp_ctrl #(
    // extra phase stages ahead of the output register
    parameter PHASE_DELAY = 1,
    // ram address width, begin field is cut to it
    parameter RAM_AW      = 10
) (
    input  wire              i_mclk,
    input  wire              i_rst,
    input  wire              i_psel,
    input  wire              i_penable,
    input  wire              i_pwrite,
    input  wire [11:0]       i_paddr,
    input  wire [31:0]       i_pwdata,
    output wire              o_pready,
    output wire [31:0]       o_prdata,
    output wire              o_pslverr,
    input  wire              i_io_update,
    input  wire              i_profile_select_low,
    input  wire              i_profile_select_high,
    input  wire              i_shaped_keying,
    input  wire [31:0]       i_ram_word,
    output reg  [RAM_AW-1:0] o_ram_addr,
    output reg  [31:0]       o_frequency_tuning_word,
    output reg  [13:0]       o_phase_offset_word,
    output reg  [13:0]       o_scale_factor,
    output reg               o_clear_phase_acc,
    output reg               o_clear_sweep_acc,
    output reg               o_sweep_start,
    output reg  [2:0]        o_ram_mode
);

    // =====================================================================
    // pin synchronisers
    reg  [1:0] upd_sync;
    reg  [1:0] psl_sync;
    reg  [1:0] psh_sync;
    reg  [1:0] osk_sync;
    reg        upd_prev;
    reg  [1:0] prof_prev;
    reg        osk_prev;
    wire [1:0] profile    = {psh_sync[1], psl_sync[1]};
    wire       upd_rise   = upd_sync[1] & ~upd_prev;
    wire       prof_chg   = (profile != prof_prev);
    wire       osk_toggle = (osk_sync[1] != osk_prev);
    wire       upd_event  = upd_rise | prof_chg;

    // two flops per pin, then edge history
    // edge flops reset to the idle low level of the pins
    always @(posedge i_mclk) begin
        if (i_rst) begin
            upd_sync  <= 2'h0;
            psl_sync  <= 2'h0;
            psh_sync  <= 2'h0;
            osk_sync  <= 2'h0;
            upd_prev  <= 1'b0;
            prof_prev <= 2'h0;
            osk_prev  <= 1'b0;
        end else begin
            upd_sync  <= {upd_sync[0], i_io_update};
            psl_sync  <= {psl_sync[0], i_profile_select_low};
            psh_sync  <= {psh_sync[0], i_profile_select_high};
            osk_sync  <= {osk_sync[0], i_shaped_keying};
            upd_prev  <= upd_sync[1];
            prof_prev <= profile;
            osk_prev  <= osk_sync[1];
        end
    end

    // =====================================================================
    // buffered and active registers
    reg [31:0] ctrl_buf;
    reg [31:0] tune_buf;
    reg [13:0] phase_buf;
    reg [15:0] amp_buf;
    reg [7:0]  rate_buf;
    reg [31:0] seg_buf [0:3];
    reg [31:0] control_function_reg_one;
    reg [31:0] static_tuning_reg;
    reg [13:0] static_phase_offset_reg;
    reg [15:0] amplitude_scale_register;
    reg [7:0]  ramp_rate_value;
    reg [31:0] ram_segment_control_word [0:3];

    wire apb_wr = i_psel & i_penable & i_pwrite;
    integer k;                                  // loop index of the buffer process
    integer n;                                  // loop index of the active copy process

    // apb writes land in the buffer only
    // status offset is read-only, writes there fall to default
    always @(posedge i_mclk) begin
        if (i_rst) begin
            ctrl_buf  <= `CTRL_BUF_RST;
            tune_buf  <= 32'h0000_0000;
            phase_buf <= 14'h0000;
            amp_buf   <= 16'h0000;
            rate_buf  <= 8'h00;
            for (k = 0; k < 4; k = k + 1)
                seg_buf[k] <= 32'h0000_0000;
        end else if (apb_wr) begin
            case (i_paddr)
                `OFS_CTRL:     ctrl_buf   <= i_pwdata;
                `OFS_TUNING:   tune_buf   <= i_pwdata;
                `OFS_PHASE:    phase_buf  <= i_pwdata[13:0];
                `OFS_AMPL:     amp_buf    <= i_pwdata[15:0];
                `OFS_RAMPRATE: rate_buf   <= i_pwdata[7:0];
                `OFS_SEG0:     seg_buf[0] <= i_pwdata;
                `OFS_SEG1:     seg_buf[1] <= i_pwdata;
                `OFS_SEG2:     seg_buf[2] <= i_pwdata;
                `OFS_SEG3:     seg_buf[3] <= i_pwdata;
                default:       ;
            endcase
        end
    end

    // update rising edge copies buffer to active
    // profile pin changes alone never copy the buffers
    always @(posedge i_mclk) begin
        if (i_rst) begin
            control_function_reg_one <= `CTRL_ACTIVE_RST;
            static_tuning_reg        <= 32'h0000_0000;
            static_phase_offset_reg  <= 14'h0000;
            amplitude_scale_register <= 16'h0000;
            ramp_rate_value          <= 8'h00;
            for (n = 0; n < 4; n = n + 1)
                ram_segment_control_word[n] <= 32'h0000_0000;
        end else if (upd_rise) begin
            control_function_reg_one <= ctrl_buf;
            static_tuning_reg        <= tune_buf;
            static_phase_offset_reg  <= phase_buf;
            amplitude_scale_register <= amp_buf;
            ramp_rate_value          <= rate_buf;
            for (n = 0; n < 4; n = n + 1)
                ram_segment_control_word[n] <= seg_buf[n];
        end
    end

    // =====================================================================
    // control field decode
    wire ram_en   = control_function_reg_one[`CF_RAM_EN];
    wire ram_dest = control_function_reg_one[`CF_RAM_DEST];
    wire load_rr  = control_function_reg_one[`CF_LOAD_RR];
    wire osk_en   = control_function_reg_one[`CF_OSK_EN];
    wire osk_auto = control_function_reg_one[`CF_OSK_AUTO];
    wire aclr_sw  = control_function_reg_one[`CF_ACLR_SWEEP];
    wire aclr_ph  = control_function_reg_one[`CF_ACLR_PHASE];
    wire cclr_sw  = control_function_reg_one[`CF_CCLR_SWEEP];
    wire cclr_ph  = control_function_reg_one[`CF_CCLR_PHASE];

    wire [31:0] cur_seg   = ram_segment_control_word[profile];
    wire [2:0]  raw_mode  = cur_seg[`SEG_MODE_HI:`SEG_MODE_LO];
    wire [RAM_AW-1:0] seg_begin = cur_seg[`SEG_BEGIN_LO+RAM_AW-1:`SEG_BEGIN_LO];
    reg  [2:0]  dec_mode;

    // segment mode decode, unknown codes fall to direct switch
    always @* begin
        case (raw_mode)
            `MODE_RAMPUP: dec_mode = `MODE_RAMPUP;
            `MODE_BIDIR:  dec_mode = `MODE_BIDIR;
            `MODE_CBIDIR: dec_mode = `MODE_CBIDIR;
            `MODE_RECIRC: dec_mode = `MODE_RECIRC;
            default:      dec_mode = `MODE_DIRECT;
        endcase
    end

    // =====================================================================
    // ram address, mode and sweep restart
    // restart waits one cycle so an update edge sees the fresh segment words
    reg evt_late;

    always @(posedge i_mclk) begin
        if (i_rst) begin
            evt_late      <= 1'b0;
            o_ram_addr    <= {RAM_AW{1'b0}};
            o_ram_mode    <= `MODE_DIRECT;
            o_sweep_start <= 1'b0;
        end else begin
            evt_late      <= upd_event;
            o_ram_mode    <= dec_mode;
            o_sweep_start <= ram_en & evt_late;
            // direct switch holds begin address, sweeps reload it on events
            if (dec_mode == `MODE_DIRECT || evt_late)
                o_ram_addr <= seg_begin;
        end
    end

    // =====================================================================
    // tuning word and phase offset sources with matched latency
    wire        ram_to_freq = ram_en & ~ram_dest;
    wire        ram_to_phase = ram_en & ram_dest;
    wire [13:0] phase_src = ram_to_phase ? i_ram_word[`RAM_PHASE_HI:`RAM_PHASE_LO]
                                         : static_phase_offset_reg;
    localparam                    PW = 14;                       // phase offset word width
    wire [PW*(PHASE_DELAY+1)-1:0] phase_taps;

    // tap 0 is the selected source, each stage feeds the next tap
    assign phase_taps[PW-1:0] = phase_src;

    genvar g;
    generate
        for (g = 0; g < PHASE_DELAY; g = g + 1) begin : g_phase_dly
            reg [PW-1:0] stage;

            // delay stage matching the tuning word register
            always @(posedge i_mclk) begin
                if (i_rst)
                    stage <= {PW{1'b0}};
                else
                    stage <= phase_taps[PW*g +: PW];
            end

            assign phase_taps[PW*(g+1) +: PW] = stage;
        end
    endgenerate

    // word output as fraction of full turn over 2^14
    always @(posedge i_mclk) begin
        if (i_rst) begin
            o_frequency_tuning_word <= 32'h0000_0000;
            o_phase_offset_word     <= 14'h0000;
        end else begin
            o_frequency_tuning_word <= ram_to_freq ? i_ram_word : static_tuning_reg;
            o_phase_offset_word     <= phase_taps[PW*PHASE_DELAY +: PW];
        end
    end

    // =====================================================================
    // accumulator clears: continuous level or one pulse per event
    // continuous clear wins as a level over the auto pulse
    always @(posedge i_mclk) begin
        if (i_rst) begin
            o_clear_phase_acc <= 1'b1;
            o_clear_sweep_acc <= 1'b0;
        end else begin
            o_clear_phase_acc <= cclr_ph | (aclr_ph & upd_event);
            o_clear_sweep_acc <= cclr_sw | (aclr_sw & upd_event);
        end
    end

    // =====================================================================
    // shaped keying ramp timer and scale counter
    wire        auto_on  = osk_en & osk_auto;
    reg         auto_prev;
    reg  [7:0]  ramp_timer;
    reg  [13:0] scale_cnt;
    wire [13:0] limit    = amplitude_scale_register[`AMP_VAL_HI:0];
    wire [1:0]  step_sel = amplitude_scale_register[`AMP_STEP_HI:`AMP_STEP_LO];
    wire [14:0] step     = 15'h0001 << step_sel;
    wire [14:0] up_sum   = {1'b0, scale_cnt} + step;
    wire        tick     = auto_on && (ramp_timer <= `RAMP_TIMER_ONE);
    wire        early_ld = osk_toggle | upd_rise | prof_chg
                         | (load_rr & upd_event)
                         | (auto_on & ~auto_prev);

    // timer counts down and reloads at one or on early load
    // reload value is the 8-bit ramp rate, not the scale limit
    always @(posedge i_mclk) begin
        if (i_rst) begin
            ramp_timer <= 8'h00;
            auto_prev  <= 1'b0;
        end else begin
            auto_prev <= auto_on;
            if (early_ld || tick)
                ramp_timer <= ramp_rate_value;
            else if (auto_on)
                ramp_timer <= ramp_timer - 8'h01;
        end
    end

    // counter steps with keying pin, clamped to zero and limit
    always @(posedge i_mclk) begin
        if (i_rst) begin
            scale_cnt <= `SCALE_ZERO;
        end else if (tick && !early_ld) begin
            if (osk_sync[1]) begin
                if (up_sum > {1'b0, limit})
                    scale_cnt <= limit;
                else
                    scale_cnt <= up_sum[13:0];
            end else begin
                if ({1'b0, scale_cnt} < step)
                    scale_cnt <= `SCALE_ZERO;
                else
                    scale_cnt <= scale_cnt - step[13:0];
            end
        end
    end

    // unsigned multiplier factor to the datapath
    always @(posedge i_mclk) begin
        if (i_rst)
            o_scale_factor <= `SCALE_FULL;
        else if (!osk_en)
            o_scale_factor <= `SCALE_FULL;
        else if (osk_auto)
            o_scale_factor <= scale_cnt;
        else
            o_scale_factor <= limit;
    end

    // =====================================================================
    // apb read mux, zero wait, error on unmapped
    reg [31:0] rd_mux;
    reg        rd_hit;

    // buffered values read back, status shows live state
    always @* begin
        rd_hit = 1'b1;
        case (i_paddr)
            `OFS_CTRL:     rd_mux = ctrl_buf;
            `OFS_TUNING:   rd_mux = tune_buf;
            `OFS_PHASE:    rd_mux = {18'h00000, phase_buf};
            `OFS_AMPL:     rd_mux = {16'h0000, amp_buf};
            `OFS_RAMPRATE: rd_mux = {24'h000000, rate_buf};
            `OFS_SEG0:     rd_mux = seg_buf[0];
            `OFS_SEG1:     rd_mux = seg_buf[1];
            `OFS_SEG2:     rd_mux = seg_buf[2];
            `OFS_SEG3:     rd_mux = seg_buf[3];
            `OFS_STATUS:   rd_mux = {13'h0000, profile, o_ram_mode, scale_cnt};
            default: begin
                rd_mux = 32'h0000_0000;
                rd_hit = 1'b0;
            end
        endcase
    end

    reg [31:0] prdata;

    // pready tied high, every access ends in its first access cycle
    assign o_pready  = 1'b1;
    assign o_prdata  = prdata;
    assign o_pslverr = i_psel & i_penable & ~rd_hit;

    // read data registered in setup phase
    always @(posedge i_mclk) begin
        if (i_rst)
            prdata <= 32'h0000_0000;
        else if (i_psel && !i_penable && !i_pwrite)
            prdata <= rd_mux;
    end

endmodule

// [test/dds_ram_model.sv]
// external waveform ram seen by the control block, one 32-bit word per address
// assumes the control block presents the address from a register and reads
// the word back in the same cycle, so the model answers combinationally
`timescale 1ns/100ps
module dds_ram_model (
    input  wire [9:0]  i_addr,
    output wire [31:0] o_word
);
    // =========================================================
    // content
    // word pattern differs per address so a wrong address shows up
    assign o_word = {i_addr[5:0] ^ 6'h2A, i_addr, 6'h15, i_addr};
endmodule

// [test/dds_ctrl_monitor.sv]
// concurrent checks on the ports of the phase, amplitude and ram mode control block
// assumes one clock domain and pins driven just after rising clock edges
`timescale 1ns/100ps
module dds_ctrl_monitor (
    input wire        i_mclk,
    input wire        i_rst,
    input wire        i_psel,
    input wire        i_penable,
    input wire        i_pwrite,
    input wire [11:0] i_paddr,
    input wire        o_pready,
    input wire [31:0] o_prdata,
    input wire        o_pslverr,
    input wire        i_io_update,
    input wire        i_profile_select_low,
    input wire        i_profile_select_high,
    input wire [31:0] o_frequency_tuning_word,
    input wire [13:0] o_phase_offset_word,
    input wire [13:0] o_scale_factor,
    input wire        o_clear_phase_acc,
    input wire        o_clear_sweep_acc,
    input wire        o_sweep_start,
    input wire [2:0]  o_ram_mode
);
    // =========================================================
    // helper: cycles since the last update or profile pin change
    logic [2:0] pins_q;
    logic [3:0] ev_age;
    always @(posedge i_mclk) begin
        pins_q <= {i_io_update, i_profile_select_high, i_profile_select_low};
        if (i_rst)
            ev_age <= 4'hF;
        else if (pins_q != {i_io_update, i_profile_select_high, i_profile_select_low})
            ev_age <= 4'h0;
        else if (ev_age != 4'hF)
            ev_age <= ev_age + 4'h1;
    end
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    // =========================================================
    // sequences
    sequence s_one_pulse;
        o_sweep_start ##1 !o_sweep_start;
    endsequence
    sequence s_recent_event;
        ev_age <= 4'hA;
    endsequence
    // =========================================================
    // assertions
    a_ready_always: assert property (o_pready)
        else $error("pready dropped");
    a_err_unmapped: assert property (i_psel && i_penable && i_paddr > 12'h024 |-> o_pslverr && (i_pwrite || o_prdata == 32'h0))
        else $error("unmapped access not refused");
    a_err_mapped: assert property (i_psel && i_penable && i_paddr <= 12'h024 && i_paddr[1:0] == 2'h0 |-> !o_pslverr)
        else $error("mapped access refused");
    a_mode_legal: assert property (o_ram_mode <= 3'h4)
        else $error("ram mode out of range");
    a_sweep_single: assert property (o_sweep_start |-> s_one_pulse)
        else $error("sweep start longer than one cycle");
    a_sweep_cause: assert property (o_sweep_start |-> s_recent_event)
        else $error("sweep start without event");
    a_tuning_cause: assert property ($changed(o_frequency_tuning_word) |-> s_recent_event)
        else $error("tuning word changed without event");
    a_phase_cause: assert property ($changed(o_phase_offset_word) |-> s_recent_event)
        else $error("phase offset changed without event");
    a_clear_cause: assert property ($rose(o_clear_phase_acc) || $rose(o_clear_sweep_acc) |-> s_recent_event)
        else $error("accumulator clear without event");
    a_ramp_step: assert property ($changed(o_scale_factor) && ev_age > 4'hA |->
        (o_scale_factor - $past(o_scale_factor) <= 14'h0008) || ($past(o_scale_factor) - o_scale_factor <= 14'h0008))
        else $error("scale step larger than eight");
endmodule
bind dds_phase_amp_ctrl dds_ctrl_monitor i_mon (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_paddr(i_paddr), .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr),
    .i_io_update(i_io_update), .i_profile_select_low(i_profile_select_low),
    .i_profile_select_high(i_profile_select_high), .o_frequency_tuning_word(o_frequency_tuning_word),
    .o_phase_offset_word(o_phase_offset_word), .o_scale_factor(o_scale_factor),
    .o_clear_phase_acc(o_clear_phase_acc), .o_clear_sweep_acc(o_clear_sweep_acc),
    .o_sweep_start(o_sweep_start), .o_ram_mode(o_ram_mode));

// [test/test_dds_phase_amp_ctrl.sv]
// self-checking bench: apb master, host pins and ram model around the control block
// assumes the register map header is on the include path
`timescale 1ns/100ps
`include "dds_ctrl_defs.vh"
module test_dds_phase_amp_ctrl;
    logic        i_mclk, i_rst, psel, penable, pwrite, io_upd, keying, o_pready, o_pslverr, slv;
    logic        clr_p, clr_s, sweep;
    logic [1:0]  prof;
    logic [2:0]  mode, m;
    logic [9:0]  ram_addr;
    logic [11:0] paddr;
    logic [13:0] phase, scale;
    logic [31:0] pwdata, prdata, rdata, ram_word, tuning;
    logic [9:0]  beg [0:3] = '{10'h005, 10'h0A3, 10'h1F0, 10'h3FE};
    integer      error_cnt = 0, checks = 0, cycles = 0, np, ns, nw, k, p, r;
    dds_phase_amp_ctrl i_dds_phase_amp_ctrl (.i_mclk(i_mclk), .i_rst(i_rst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(o_pready), .o_prdata(prdata),
        .o_pslverr(o_pslverr), .i_io_update(io_upd), .i_profile_select_low(prof[0]),
        .i_profile_select_high(prof[1]), .i_shaped_keying(keying), .i_ram_word(ram_word), .o_ram_addr(ram_addr),
        .o_frequency_tuning_word(tuning), .o_phase_offset_word(phase), .o_scale_factor(scale),
        .o_clear_phase_acc(clr_p), .o_clear_sweep_acc(clr_s), .o_sweep_start(sweep), .o_ram_mode(mode));
    dds_ram_model i_dds_ram_model (.i_addr(ram_addr), .o_word(ram_word));
    // =========================================================
    // clock and hang guard
    initial begin
        i_mclk = 1'b0;
        forever #4 i_mclk = ~i_mclk;
    end
    always @(posedge i_mclk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            error_cnt = error_cnt + 1;
            end_sim();
        end
    end
    // =========================================================
    // tasks
    function automatic logic [31:0] ramw(input logic [9:0] a);
        ramw = {a[5:0] ^ 6'h2A, a, 6'h15, a};
    endfunction
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // one apb transfer, held until pready is sampled high
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge i_mclk);
        psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d; penable <= 1'b0;
        @(posedge i_mclk);
        penable <= 1'b1;
        @(posedge i_mclk);
        while (o_pready !== 1'b1) @(posedge i_mclk);
        rdata = prdata;
        slv = o_pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    // update pulse and/or profile change, counting clear pulses meanwhile
    task ev(input logic u, input logic [1:0] pr);
        integer j;
        np = 0; ns = 0;
        nw = 0;
        @(posedge i_mclk);
        io_upd <= u; prof <= pr;
        for (j = 0; j < 14; j++) begin
            @(posedge i_mclk);
            if (j == 2) io_upd <= 1'b0;
            np = np + (clr_p === 1'b1);
            ns = ns + (clr_s === 1'b1);
            nw = nw + (sweep === 1'b1);
        end
    endtask
    task wait_scale(input logic zero);
        k = 0;
        while (((scale === 14'h0000) != zero) && k < 300) begin
            @(posedge i_mclk);
            k = k + 1;
        end
    endtask
    task end_sim;
        if (error_cnt == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // =========================================================
    // main sequence
    initial begin
        i_rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
        io_upd = 1'b0; prof = 2'h0; keying = 1'b0;
        repeat (4) @(posedge i_mclk);
        i_rst <= 1'b0;
        check("reset clear", clr_p, 1);
        check("reset scale", scale, `SCALE_FULL);
        apb(1, `OFS_TUNING, 32'hA5C3_1E07);
        apb(1, `OFS_PHASE, 32'h0000_2B5D);
        apb(0, `OFS_TUNING, 0);
        check("tuning readback", rdata, 32'hA5C3_1E07);
        check("tuning before update", tuning, 0);
        ev(1, 0);
        check("tuning", tuning, 32'hA5C3_1E07);
        check("phase", phase, 14'h2B5D);
        check("clear released", clr_p, 0);
        apb(0, 12'h0FC, 0);
        check("unmapped err", slv, 1);
        check("unmapped data", rdata, 0);
        // mixed clear modes, one accumulator each way
        apb(1, `OFS_CTRL, 32'h0000_2800);
        ev(1, 0);
        ev(1, 0);
        check("auto clear on update", np, 1);
        ev(0, 1);
        check("auto clear on profile", np, 1);
        check("cont sweep clear", clr_s, 1);
        apb(1, `OFS_CTRL, 32'h0000_4400);
        ev(1, 1);
        ev(1, 1);
        check("auto sweep clear", ns, 1);
        check("cont phase clear", clr_p, 1);
        apb(1, `OFS_CTRL, 0);
        ev(1, 0);
        check("clears off", {clr_p, clr_s}, 0);
        // automatic keying, every step code
        apb(1, `OFS_RAMPRATE, 2);
        for (r = 0; r < 4; r++) begin
            apb(1, `OFS_AMPL, {16'h0, r[1:0], 14'h3FFF});
            apb(1, `OFS_CTRL, 32'h0300_0000);
            ev(1, 0);
            check("auto start", scale, 0);
            keying <= 1'b1;
            wait_scale(0);
            check("first step", scale, 14'h1 << r);
            keying <= 1'b0;
            wait_scale(1);
            check("ramp down", scale, 0);
        end
        apb(1, `OFS_AMPL, {16'h0, 2'h3, 14'h0013});
        ev(1, 0);
        keying <= 1'b1;
        repeat (150) @(posedge i_mclk);
        check("limit clamp", scale, 14'h0013);
        apb(0, `OFS_STATUS, 0);
        check("status counter", rdata, 32'h0000_0013);
        keying <= 1'b0;
        repeat (150) @(posedge i_mclk);
        check("zero clamp", scale, 0);
        apb(1, `OFS_AMPL, 32'h0000_5234);
        apb(1, `OFS_CTRL, 32'h0200_0000);
        ev(1, 0);
        check("manual scale", scale, 14'h1234);
        apb(1, `OFS_CTRL, 0);
        ev(1, 0);
        check("keying off", scale, `SCALE_FULL);
        // ram direct switch and segment modes, frequency then phase destination
        for (r = 0; r < 2; r++) begin
            for (k = 0; k < 4; k++)
                apb(1, `OFS_SEG0 + 4 * k, {2'h0, 10'h3FF, beg[k], 2'h0, 3'(k + 4 * r), 5'h0});
            apb(1, `OFS_CTRL, r ? 32'hC000_0000 : 32'h8000_0000);
            ev(1, 0);
            for (k = 0; k < 4; k++) begin
                p = (k + 1) % 4;
                m = 3'(p + 4 * r);
                ev(0, p[1:0]);
                check("ram addr", ram_addr, beg[p]);
                check("sweep pulse", nw, 1);
                check("ram mode", mode, (m <= 3'h4) ? m : 3'h0);
                if (r == 0) check("ram tuning", tuning, ramw(beg[p]));
                else check("ram phase", phase, ramw(beg[p]) >> 18);
            end
        end
        end_sim();
    end
endmodule
